/* core/fpb_pkg.sv */
// Purpose: Shared constants for the flash block-protect and bus-sequencing host controller.
// Assumes: Controller clock of 250 MHz; flash commands carried in the low data byte.
// Notes:   Bus-cycle phase lengths are in controller cycles; long waits derive from times.
package fpb_pkg;

    // ==========================================================
    // Clock and waits
    // ==========================================================
    // Controller clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 4;
    // Settling time after raising the reset pin to the high level, in microseconds.
    localparam int VID_WAIT_US = 4;
    // Time between the second protect write and the final protect write, in microseconds.
    localparam int PROT_WAIT_US = 100;
    // Least waits round up to whole cycles.
    localparam int VID_WAIT_CYC = (VID_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROT_WAIT_CYC = (PROT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Bus cycle phases, in controller cycles
    // ==========================================================
    // Address and select set up before the strobe falls.
    localparam logic [7:0] BC_SETUP_CYC = 8'h01;
    // Write strobe low time; data stands on the bus throughout.
    localparam logic [7:0] BC_WR_PULSE_CYC = 8'h03;
    // Output enable low time before read data is sampled.
    localparam logic [7:0] BC_RD_ACCESS_CYC = 8'h14;
    // Hold after the strobe rises.
    localparam logic [7:0] BC_HOLD_CYC = 8'h01;
    // Bus release time so the memory stops driving before the next cycle.
    localparam logic [7:0] BC_TURN_CYC = 8'h04;

    // ==========================================================
    // Commands and protect sequence values
    // ==========================================================
    localparam logic [7:0] CMD_PROTECT_SETUP = 8'h60;
    localparam logic [7:0] CMD_PROTECT_GO = 8'h40;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] PROTECT_VERIFY_OK = 8'h01;
    localparam logic [4:0] PROTECT_MAX_ATTEMPTS = 5'h19;
    // Identification read address bit positions and their values in a protect address.
    localparam int ID_BIT_A6 = 6;
    localparam int ID_BIT_A1 = 1;
    localparam int ID_BIT_A0 = 0;
    localparam logic ID_VAL_A6 = 1'b0;
    localparam logic ID_VAL_A1 = 1'b1;
    localparam logic ID_VAL_A0 = 1'b0;
    // Bit of the status word that alternates while an automatic operation runs.
    localparam int TOGGLE_BIT = 6;

    // ==========================================================
    // User operations
    // ==========================================================
    typedef enum logic [1:0] {
        FPB_OP_WRITE,
        FPB_OP_READ,
        FPB_OP_POLL,
        FPB_OP_PROTECT
    } fpb_op_t;

endpackage : fpb_pkg

/* core/fpb_bus_cycle.sv */
// Purpose: Runs one asynchronous flash read or write cycle on the memory pins.
// Assumes: Read data on the pins is synchronous to mclk when sampled.
// Notes:   Strobes and selects idle high; data drive is released before done.
`timescale 1ns/10ps
module fpb_bus_cycle
    import fpb_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    // Clock and synchronised reset.
    input wire logic mclk,
    input wire logic rst_sync_n,
    // Cycle request and answer.
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // Memory pins.
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    output logic we_n,
    output logic oe_n,
    output logic flash_select_n
);

    // ==========================================================
    // Phase sequencer
    // ==========================================================
    typedef enum logic [2:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD, BC_TURN} fpb_bc_t;
    fpb_bc_t state_ff;
    logic [7:0] cnt_ff; // Cycles left in the current phase.
    logic wr_ff; // Current cycle is a write.
    logic last; // Last cycle of the current phase.

    assign last = (cnt_ff == 8'h00);

    // Steps through the phases of one cycle.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_ff <= BC_IDLE;
            cnt_ff <= 8'h00;
            wr_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                BC_IDLE: begin
                    if (start) begin
                        state_ff <= BC_SETUP;
                        cnt_ff <= BC_SETUP_CYC - 8'h01;
                        wr_ff <= is_write;
                    end
                end
                BC_SETUP: begin
                    if (last) begin
                        state_ff <= BC_STROBE;
                        cnt_ff <= wr_ff ? BC_WR_PULSE_CYC - 8'h01 : BC_RD_ACCESS_CYC - 8'h01;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                BC_STROBE: begin
                    if (last) begin
                        state_ff <= BC_HOLD;
                        cnt_ff <= BC_HOLD_CYC - 8'h01;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                BC_HOLD: begin
                    if (last) begin
                        state_ff <= BC_TURN;
                        cnt_ff <= BC_TURN_CYC - 8'h01;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                BC_TURN: begin
                    if (last) begin
                        state_ff <= BC_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Pin drive
    // ==========================================================
    // Strobes idle high from reset so no spurious command edge is made at power-up.
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            we_n <= 1'b1;
            oe_n <= 1'b1;
            flash_select_n <= 1'b1;
            mem_addr <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
            rdata <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_ff)
                BC_IDLE: begin
                    if (start) begin
                        mem_addr <= addr;
                        flash_select_n <= 1'b0;
                        dq_out <= wdata;
                        // Data drives only for writes; reads leave the bus to the memory.
                        dq_oe <= is_write;
                    end
                end
                BC_SETUP: begin
                    if (last) begin
                        // Write strobe stays high through any read.
                        we_n <= ~wr_ff;
                        oe_n <= wr_ff;
                    end
                end
                BC_STROBE: begin
                    if (last) begin
                        // Write data has stood with the strobe low for several cycles.
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (!wr_ff) begin
                            rdata <= dq_in;
                        end
                    end
                end
                BC_HOLD: begin
                    if (last) begin
                        dq_oe <= 1'b0;
                        flash_select_n <= 1'b1;
                    end
                end
                BC_TURN: begin
                    // Nobody drives here while the memory outputs float off.
                    if (last) begin
                        done <= 1'b1;
                    end
                end
            endcase
        end
    end

endmodule : fpb_bus_cycle

/* core/fpb_host.sv */
// Purpose: Host controller for a flash and SRAM memory package: single cycles,
//          toggle-bit polling and the raised-voltage block protect sequence.
// Assumes: One clock mclk at 250 MHz; memory pins are sampled synchronously.
// Notes:   The SRAM is held deselected; only the flash is addressed.
`timescale 1ns/10ps

module fpb_host
    import fpb_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16,
    parameter int PROT_WAIT = PROT_WAIT_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // User command port.
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_data,
    output logic cmd_ready,
    // User answer port.
    output logic rsp_done,
    output logic [DATA_W-1:0] rsp_data,
    output logic rsp_fail,
    // Flash pins.
    output logic [ADDR_W-1:0] mem_addr,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in,
    output logic we_n,
    output logic oe_n,
    output logic flash_select_n,
    // SRAM selects, held inactive.
    output logic sram_select_active_low,
    output logic sram_select_active_high,
    // Reset pin high-voltage request.
    output logic raised_reset_voltage
);

    // ==========================================================
    // Reset synchroniser
    // ==========================================================
    logic rst_meta_ff; // First stage, read only by the second.
    logic rst_sync_ff; // Synchronised active-low reset.

    // Asserts at once, releases after two edges.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ==========================================================
    // Protect address helper
    // ==========================================================
    // Places the identification read pattern into a block address.
    function automatic logic [ADDR_W-1:0] prot_addr(input logic [ADDR_W-1:0] blk);
        logic [ADDR_W-1:0] a;
        a = blk;
        a[ID_BIT_A6] = ID_VAL_A6;
        a[ID_BIT_A1] = ID_VAL_A1;
        a[ID_BIT_A0] = ID_VAL_A0;
        return a;
    endfunction : prot_addr

    // ==========================================================
    // Bus cycle engine
    // ==========================================================
    logic bc_start_ff; // One-cycle start pulse.
    logic bc_write_ff; // Requested cycle is a write.
    logic [ADDR_W-1:0] bc_addr_ff; // Requested address.
    logic [DATA_W-1:0] bc_data_ff; // Requested write data.
    logic bc_done; // Cycle finished, bus released.
    logic [DATA_W-1:0] bc_rdata; // Data of the last read.

    fpb_bus_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_cycle (
        .mclk(mclk),
        .rst_sync_n(rst_sync_ff),
        .start(bc_start_ff),
        .is_write(bc_write_ff),
        .addr(bc_addr_ff),
        .wdata(bc_data_ff),
        .done(bc_done),
        .rdata(bc_rdata),
        .mem_addr(mem_addr),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .dq_in(dq_in),
        .we_n(we_n),
        .oe_n(oe_n),
        .flash_select_n(flash_select_n)
    );

    // ==========================================================
    // Sequencer
    // ==========================================================
    typedef enum logic [3:0] {
        ST_IDLE, ST_SINGLE, ST_POLL, ST_VID_WAIT, ST_PW1, ST_PW2, ST_PWAIT,
        ST_PW3, ST_PVERIFY, ST_PRESET
    } fpb_state_t;
    fpb_state_t state_ff;
    logic [15:0] timer_ff; // Wait counter.
    logic [4:0] attempt_ff; // Protect attempt count.
    logic [ADDR_W-1:0] blk_ff; // Block or poll address.
    logic last_tog_ff; // Toggle bit from the previous poll read.
    logic poll_first_ff; // Next poll read is the first.
    logic fail_ff; // Protect ran out of attempts.

    // Requests one bus cycle on the next edge.
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bc_start_ff <= 1'b1;
        bc_write_ff <= wr;
        bc_addr_ff <= a;
        bc_data_ff <= d;
    endtask : issue

    // Main control: accepts user operations and walks the protect flow.
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= ST_IDLE;
            timer_ff <= 16'h0000;
            attempt_ff <= 5'h00;
            blk_ff <= '0;
            last_tog_ff <= 1'b0;
            poll_first_ff <= 1'b0;
            fail_ff <= 1'b0;
            bc_start_ff <= 1'b0;
            bc_write_ff <= 1'b0;
            bc_addr_ff <= '0;
            bc_data_ff <= '0;
            cmd_ready <= 1'b0;
            rsp_done <= 1'b0;
            rsp_data <= '0;
            rsp_fail <= 1'b0;
            raised_reset_voltage <= 1'b0;
        end else begin
            bc_start_ff <= 1'b0;
            rsp_done <= 1'b0;
            cmd_ready <= (state_ff == ST_IDLE) && !cmd_valid;
            unique case (state_ff)
                ST_IDLE: begin
                    // A command is taken when ready was shown the cycle before.
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        blk_ff <= cmd_addr;
                        unique case (fpb_op_t'(cmd_op))
                            FPB_OP_WRITE: begin
                                issue(1'b1, cmd_addr, cmd_data);
                                state_ff <= ST_SINGLE;
                            end
                            FPB_OP_READ: begin
                                issue(1'b0, cmd_addr, '0);
                                state_ff <= ST_SINGLE;
                            end
                            FPB_OP_POLL: begin
                                // Poll address is the user's programmed or erasing address.
                                issue(1'b0, cmd_addr, '0);
                                poll_first_ff <= 1'b1;
                                state_ff <= ST_POLL;
                            end
                            FPB_OP_PROTECT: begin
                                raised_reset_voltage <= 1'b1;
                                timer_ff <= 16'(VID_WAIT_CYC - 1);
                                attempt_ff <= 5'h01;
                                fail_ff <= 1'b0;
                                state_ff <= ST_VID_WAIT;
                            end
                        endcase
                    end
                end
                ST_SINGLE: begin
                    if (bc_done) begin
                        rsp_data <= bc_rdata;
                        rsp_fail <= 1'b0;
                        rsp_done <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_POLL: begin
                    // Busy while the toggle bit differs between two reads.
                    if (bc_done) begin
                        last_tog_ff <= bc_rdata[TOGGLE_BIT];
                        poll_first_ff <= 1'b0;
                        if (!poll_first_ff && bc_rdata[TOGGLE_BIT] == last_tog_ff) begin
                            rsp_data <= bc_rdata;
                            rsp_fail <= 1'b0;
                            rsp_done <= 1'b1;
                            state_ff <= ST_IDLE;
                        end else begin
                            issue(1'b0, blk_ff, '0);
                        end
                    end
                end
                ST_VID_WAIT: begin
                    if (timer_ff == 16'h0000) begin
                        issue(1'b1, '0, DATA_W'(CMD_PROTECT_SETUP));
                        state_ff <= ST_PW1;
                    end else begin
                        timer_ff <= timer_ff - 16'h0001;
                    end
                end
                ST_PW1: begin
                    if (bc_done) begin
                        issue(1'b1, prot_addr(blk_ff), DATA_W'(CMD_PROTECT_SETUP));
                        state_ff <= ST_PW2;
                    end
                end
                ST_PW2: begin
                    if (bc_done) begin
                        timer_ff <= 16'(PROT_WAIT - 1);
                        state_ff <= ST_PWAIT;
                    end
                end
                ST_PWAIT: begin
                    if (timer_ff == 16'h0000) begin
                        issue(1'b1, '0, DATA_W'(CMD_PROTECT_GO));
                        state_ff <= ST_PW3;
                    end else begin
                        timer_ff <= timer_ff - 16'h0001;
                    end
                end
                ST_PW3: begin
                    if (bc_done) begin
                        issue(1'b0, prot_addr(blk_ff), '0);
                        state_ff <= ST_PVERIFY;
                    end
                end
                ST_PVERIFY: begin
                    if (bc_done) begin
                        rsp_data <= bc_rdata;
                        if (bc_rdata[7:0] == PROTECT_VERIFY_OK) begin
                            raised_reset_voltage <= 1'b0;
                            issue(1'b1, '0, DATA_W'(CMD_RESET));
                            state_ff <= ST_PRESET;
                        end else if (attempt_ff == PROTECT_MAX_ATTEMPTS) begin
                            fail_ff <= 1'b1;
                            raised_reset_voltage <= 1'b0;
                            issue(1'b1, '0, DATA_W'(CMD_RESET));
                            state_ff <= ST_PRESET;
                        end else begin
                            attempt_ff <= attempt_ff + 5'h01;
                            issue(1'b1, '0, DATA_W'(CMD_PROTECT_SETUP));
                            state_ff <= ST_PW1;
                        end
                    end
                end
                ST_PRESET: begin
                    if (bc_done) begin
                        rsp_fail <= fail_ff;
                        rsp_done <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // SRAM selects
    // ==========================================================
    // The SRAM stays deselected so it never contends with flash on the data pins.
    always_ff @(posedge mclk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            sram_select_active_low <= 1'b1;
            sram_select_active_high <= 1'b0;
        end else begin
            sram_select_active_low <= 1'b1;
            sram_select_active_high <= 1'b0;
        end
    end

endmodule : fpb_host

/* tb/fpb_host_props.sv */
// Purpose: Concurrent checks on the pins and user port of the flash host controller.
// Assumes: Single clock mclk; rst_n is the raw asynchronous reset.
// Notes:   Bound to fpb_host below the module.
`timescale 1ns/10ps
module fpb_host_props
    import fpb_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock, reset and user port.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic rsp_done,
    // Memory pins.
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic flash_select_n,
    input wire logic sram_select_active_low,
    input wire logic sram_select_active_high,
    input wire logic raised_reset_voltage
);
    // Cycles spent with the raised voltage applied, saturating.
    logic [15:0] rv_cnt_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rv_cnt_ff <= 16'h0000;
        end else begin
            rv_cnt_ff <= !raised_reset_voltage ? 16'h0000 :
                         (rv_cnt_ff == 16'hffff) ? rv_cnt_ff : rv_cnt_ff + 16'h0001;
        end
    end
    // ==========================================================
    // Assertions
    // ==========================================================
    a_read_we_high: assert property (@(posedge mclk) disable iff (!rst_n)
        !oe_n |-> we_n) else $error("write strobe low during a read");
    a_no_drive_read: assert property (@(posedge mclk) disable iff (!rst_n)
        !oe_n |-> !dq_oe) else $error("host drives data while output enabled");
    a_sram_held_off: assert property (@(posedge mclk) disable iff (!rst_n)
        sram_select_active_low && !sram_select_active_high) else $error("sram selected");
    a_write_pulse_len: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(we_n) |-> !we_n ##1 !we_n ##1 !we_n ##1 we_n) else $error("write strobe length wrong");
    a_write_data_held: assert property (@(posedge mclk) disable iff (!rst_n)
        !we_n |-> dq_oe && !flash_select_n && $stable(dq_out)) else $error("write data moved");
    a_vid_wait_done: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(we_n) && raised_reset_voltage |-> rv_cnt_ff >= VID_WAIT_CYC)
        else $error("protect write too soon after raised voltage");
    a_reset_cmd_sent: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(raised_reset_voltage) |-> ##[1:4] (!we_n && dq_out[7:0] == CMD_RESET))
        else $error("no reset command after raised voltage");
    a_take_drops_rdy: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_valid && cmd_ready |=> !cmd_ready) else $error("ready held after take");
    a_done_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        rsp_done |=> !rsp_done) else $error("done longer than one cycle");
endmodule : fpb_host_props

bind fpb_host fpb_host_props #(.DATA_W(DATA_W)) u_props (.mclk, .rst_n, .cmd_valid,
    .cmd_ready, .rsp_done, .dq_out, .dq_oe, .we_n, .oe_n, .flash_select_n,
    .sram_select_active_low, .sram_select_active_high, .raised_reset_voltage);

/* tb/fpb_dev_model.sv */
// Purpose: Behavioural flash device answering the host controller's pins.
// Assumes: Pins sampled on mclk; array contents are a fixed pattern of the address.
// Notes:   Verify passes after PASS_AT protect pulses unless refuse is high.
`timescale 1ns/10ps
module fpb_dev_model
    import fpb_pkg::*;
#(
    parameter int PASS_AT = 3
) (
    // Clock and pins.
    input wire logic mclk,
    input wire logic [20:0] mem_addr,
    input wire logic [15:0] dq_out,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic flash_select_n,
    input wire logic raised_reset_voltage,
    input wire logic refuse,
    output logic [15:0] dq_in,
    output int go_count,
    output logic [20:0] prot_addr
);
    logic we_q = 1'b1, oe_q = 1'b1, tog = 1'b0, rv_q = 1'b0;
    logic pw = 1'b1, skip = 1'b0; // First edge after power-up; ignore next command strobe.
    logic [15:0] v;
    int busy = 0;
    initial dq_in = 16'h0000;
    // Command decode on write strobe rise, status and data on reads.
    always @(posedge mclk) begin
        we_q <= we_n;
        oe_q <= oe_n;
        rv_q <= raised_reset_voltage;
        if (raised_reset_voltage && !rv_q) go_count <= 0;
        pw <= 1'b0;
        if (pw) skip <= (we_n === 1'b0) && (flash_select_n === 1'b0);
        if (we_n && !we_q && !flash_select_n && skip === 1'b1) begin
            skip <= 1'b0;
            busy <= 0;
        end else if (we_n && !we_q && !flash_select_n) begin
            if (dq_out[7:0] == CMD_PROTECT_SETUP && mem_addr != 21'h00_0000) prot_addr <= mem_addr;
            else if (dq_out[7:0] == CMD_PROTECT_GO) go_count <= go_count + 1;
            else if (dq_out[7:0] != CMD_PROTECT_SETUP && dq_out[7:0] != CMD_RESET) busy <= 4;
        end
        if (!oe_n && oe_q && !flash_select_n && busy != 0) begin
            tog <= ~tog;
            busy <= busy - 1;
        end
        v = mem_addr[15:0] ^ 16'h5a5a;
        if (oe_n || flash_select_n) dq_in <= ~dq_in;
        else if (raised_reset_voltage && mem_addr == prot_addr)
            dq_in <= (go_count >= PASS_AT && !refuse) ? 16'h0001 : 16'h0000;
        else if (busy != 0) dq_in <= {~v[15:8], v[7:0]} ^ 16'h0080 ^ {9'h000, tog ^ v[6], 6'h00};
        else dq_in <= v;
    end
endmodule : fpb_dev_model

/* tb/fpb_host_tb_top.sv */
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Device model on the pins; inputs driven on falling edges.
// Notes:   Protect wait shortened to 20 cycles.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module fpb_host_tb_top;
    import fpb_pkg::*;
    logic mclk = 0, rst_n = 0, cmd_valid = 0, refuse = 0;
    logic cmd_ready, rsp_done, rsp_fail, dq_oe, we_n, oe_n, flash_select_n, rv;
    logic [1:0] cmd_op = 2'h0;
    logic [20:0] cmd_addr = 21'h00_0000, mem_addr, pa, a;
    logic [15:0] cmd_data = 16'h0000, rsp_data, dq_out, dq_in;
    logic [31:0] seed = 32'h6b42_6d3c;
    int fail_count = 0, n_tests = 0, gc;
    always #2 mclk = ~mclk;
    fpb_host #(.PROT_WAIT(20)) DUT (.mclk, .rst_n, .cmd_valid, .cmd_op, .cmd_addr,
        .cmd_data, .cmd_ready, .rsp_done, .rsp_data, .rsp_fail, .mem_addr, .dq_out, .dq_oe,
        .dq_in, .we_n, .oe_n, .flash_select_n, .sram_select_active_low(),
        .sram_select_active_high(), .raised_reset_voltage(rv));
    fpb_dev_model u_dev (.mclk, .mem_addr, .dq_out, .we_n, .oe_n, .flash_select_n,
        .raised_reset_voltage(rv), .refuse, .dq_in, .go_count(gc), .prot_addr(pa));
    function automatic logic [15:0] arr(input logic [20:0] x);
        return x[15:0] ^ 16'h5a5a;
    endfunction : arr
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic conclude;
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // One user operation, waiting for take and for the answer.
    task automatic run(input logic [1:0] op, input logic [20:0] ad, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        // Ready is withheld while valid waits in idle, so valid rises only after ready shows.
        while (cmd_ready !== 1'b1) @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = ad;
        cmd_data = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (rsp_done !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        `CHK("done", 1'b1, rsp_done)
    endtask : run
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            a = seed[20:0];
            run(FPB_OP_WRITE, a, seed[31:16] | 16'h0001);
            run(FPB_OP_POLL, a, 16'h0000);
            `CHK("poll", arr(a), rsp_data)
            seed = xs(seed);
            run(FPB_OP_READ, seed[20:0], 16'h0000);
            `CHK("read", arr(seed[20:0]), rsp_data)
        end
        a = 21'h1f_ffff;
        for (int k = 0; k < 2; k++) begin
            refuse = k[0];
            run(FPB_OP_PROTECT, a, 16'h0000);
            `CHK("fail", k[0], rsp_fail)
            `CHK("attempts", (k != 0) ? 25 : 3, gc)
            `CHK("verify", (k != 0) ? 8'h00 : 8'h01, rsp_data[7:0])
            `CHK("bpa", {a[20:7], 1'b0, a[5:2], 2'b10}, pa)
            `CHK("rv", 1'b0, rv)
            a = 21'h0a_5a5a;
        end
        conclude();
    end
endmodule : fpb_host_tb_top
